/* eepc_pkg.sv */
/*
  eepc_pkg: constants, types and timing for the parallel EEPROM page-write host controller.
  Assumes a 250 MHz system clock and an EEPROM whose pins the controller drives directly.
*/
// How it works
// R1 - one to sixty-four byte loads are programmed together in one internal cycle
// R2 - after the first write, each write pulse loads address and data into the buffer
// R3 - page comes from upper address bits at the last falling write edge
// R4 - low six address bits pick the byte; any order allowed
// R5 - host starts each next byte load before the byte-load window expires
// R6 - host ends a page by holding write strobe high one full window
// R7 - device erases then writes only the loaded locations of the page
// R8 - while busy, reading the last byte returns inverted data bit seven
// R9 - after the self-timed write, reads return true data on all lines
// R10 - while busy, data line six toggles on every read, then stops
// R11 - device refuses writes for five to ten ms after power is valid
// R12 - writes blocked while output gate low, chip select high or strobe high
// R13 - strobe or select low pulses shorter than 20 ns start no write
// R14 - with the lock enabled, a write needs the command prefix first
// R15 - lock is disabled as delivered, standard operating mode
// R16 - lock enable is three command writes using page-write timing
// R17 - lock holds after the three commands; data writes start within the window
// R18 - while locked, every later write is preceded by the three-write prefix
// R19 - enabled lock survives power cycling until a disable sequence arrives
// R20 - six-write sequence clears the lock; normal writes follow the sixth
// R21 - each strobe rise starts a 100 us load timer; expiry starts programming
// R22 - each internal erase-and-write cycle finishes within ten ms
// R23 - address taken on the later falling edge, data on the earlier rising
// R24 - device drives data only with strobe high and select and gate low
// R25 - command sequence addresses and data are design parameters
// R26 - writes during an internal cycle are ignored; polling still reports busy
package eepc_pkg;

  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned ADDR_W       = 15;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned BYTE_BITS    = 6;
  localparam int unsigned POLL_BIT     = 7;
  localparam int unsigned TOGGLE_BIT   = 6;
  localparam int unsigned ON_LEN       = 3;
  localparam int unsigned OFF_LEN      = 6;

  // pin timing in printed units
  localparam int unsigned WP_NS        = 150;   // write_pulse_width minimum
  localparam int unsigned BLC_MIN_NS   = 150;   // byte_load_window minimum
  localparam int unsigned BLC_MAX_US   = 100;   // byte_load_window maximum
  localparam int unsigned ACC_NS       = 300;   // slowest read access
  localparam int unsigned HZ_NS        = 60;    // output float after gate release
  localparam int unsigned INIT_MS      = 10;    // power_on_write_lockout maximum
  localparam int unsigned WC_MS        = 10;    // internal write cycle maximum

  // least times round up to whole cycles
  function automatic int unsigned ns_up(input int unsigned ns);
    ns_up = (ns * CLK_MHZ + 999) / 1000;
  endfunction

  localparam int unsigned WP_CYC       = ns_up(WP_NS);
  localparam int unsigned BLC_MIN_CYC  = ns_up(BLC_MIN_NS);
  localparam int unsigned ACC_CYC      = ns_up(ACC_NS);
  localparam int unsigned HZ_CYC       = ns_up(HZ_NS);
  localparam int unsigned BLC_MAX_CYC  = BLC_MAX_US * CLK_MHZ;
  localparam int unsigned INIT_CYC     = INIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned WC_CYC       = WC_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W        = 24;

  typedef enum logic [1:0] {
    EEPC_OP_READ,
    EEPC_OP_WRITE,
    EEPC_OP_LOCK_ON,
    EEPC_OP_LOCK_OFF
  } eepc_op_e;

  typedef struct packed {
    eepc_op_e              op;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     data;
    logic                  last;
  } eepc_req_s;

  typedef struct packed {
    logic [DATA_W-1:0]     data;
    logic                  err;
  } eepc_resp_s;

endpackage

/* eepc_ctrl.sv */
/*
  eepc_ctrl: host-side controller that drives a 32K x 8 parallel EEPROM through its pins.
  Takes read, byte/page write and lock on/off orders at a valid/ready port; assumes pin
  inputs are synchronous to clk and the EEPROM's own timing is as the constants state.
*/
`timescale 1ns/10ps
module eepc_ctrl #(
  parameter int unsigned BLC_MAX_CYC = eepc_pkg::BLC_MAX_CYC,
  parameter int unsigned INIT_CYC    = eepc_pkg::INIT_CYC,
  parameter int unsigned WC_CYC      = eepc_pkg::WC_CYC,
  // command sequences, arbitrary neutral defaults
  parameter logic [eepc_pkg::ON_LEN*eepc_pkg::ADDR_W-1:0]  ON_ADDRS  = 45'h0001_0002_0003,
  parameter logic [eepc_pkg::ON_LEN*eepc_pkg::DATA_W-1:0]  ON_DATA   = 24'h11_22_33,
  parameter logic [eepc_pkg::OFF_LEN*eepc_pkg::ADDR_W-1:0] OFF_ADDRS = 90'h1_0002_0003_0004_0005_0006,
  parameter logic [eepc_pkg::OFF_LEN*eepc_pkg::DATA_W-1:0] OFF_DATA  = 48'h44_55_66_77_88_99
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  // lock state last left in the device, sampled once after reset
  input  wire logic                          lock_strap,
  // user orders
  input  wire logic                          req_valid,
  output logic                               req_ready,
  input  wire eepc_pkg::eepc_req_s           req,
  output logic                               resp_valid,
  output eepc_pkg::eepc_resp_s               resp,
  output logic                               busy,
  output logic                               locked,
  // eeprom pins
  output logic [eepc_pkg::ADDR_W-1:0]        mem_addr,
  output logic                               mem_ce_n,
  output logic                               mem_oe_n,
  output logic                               mem_we_n,
  output logic [eepc_pkg::DATA_W-1:0]        mem_dq_o,
  output logic                               mem_dq_oe_n,
  input  wire logic [eepc_pkg::DATA_W-1:0]   mem_dq_i
);

  typedef enum {
    ST_INIT, ST_IDLE, ST_WSET, ST_WLOW, ST_WHIGH, ST_NEXT,
    ST_HOLD, ST_RLOW, ST_RGAP, ST_DONE
  } eepc_st_e;

  localparam logic [eepc_pkg::CNT_W-1:0] WP_N   = eepc_pkg::CNT_W'(eepc_pkg::WP_CYC);
  localparam logic [eepc_pkg::CNT_W-1:0] GAP_N  = eepc_pkg::CNT_W'(eepc_pkg::BLC_MIN_CYC);
  localparam logic [eepc_pkg::CNT_W-1:0] ACC_N  = eepc_pkg::CNT_W'(eepc_pkg::ACC_CYC);
  localparam logic [eepc_pkg::CNT_W-1:0] HZ_N   = eepc_pkg::CNT_W'(eepc_pkg::HZ_CYC);
  localparam logic [eepc_pkg::CNT_W-1:0] HOLD_N = eepc_pkg::CNT_W'(BLC_MAX_CYC);
  localparam logic [eepc_pkg::CNT_W-1:0] WAIT_N = eepc_pkg::CNT_W'(BLC_MAX_CYC / 2);
  localparam logic [eepc_pkg::CNT_W-1:0] INIT_N = eepc_pkg::CNT_W'(INIT_CYC);
  localparam logic [eepc_pkg::CNT_W-1:0] WC_N   = eepc_pkg::CNT_W'(WC_CYC);

  function automatic logic [eepc_pkg::ADDR_W-1:0] cmd_addr(input logic off, input logic [2:0] i);
    cmd_addr = off ? OFF_ADDRS[(eepc_pkg::OFF_LEN-1-i)*eepc_pkg::ADDR_W +: eepc_pkg::ADDR_W]
                   : ON_ADDRS[(eepc_pkg::ON_LEN-1-i)*eepc_pkg::ADDR_W +: eepc_pkg::ADDR_W];
  endfunction

  function automatic logic [eepc_pkg::DATA_W-1:0] cmd_data(input logic off, input logic [2:0] i);
    cmd_data = off ? OFF_DATA[(eepc_pkg::OFF_LEN-1-i)*eepc_pkg::DATA_W +: eepc_pkg::DATA_W]
                   : ON_DATA[(eepc_pkg::ON_LEN-1-i)*eepc_pkg::DATA_W +: eepc_pkg::DATA_W];
  endfunction

  function automatic logic same_page(input logic [eepc_pkg::ADDR_W-1:0] a,
                                     input logic [eepc_pkg::ADDR_W-1:0] b);
    same_page = a[eepc_pkg::ADDR_W-1:eepc_pkg::BYTE_BITS] == b[eepc_pkg::ADDR_W-1:eepc_pkg::BYTE_BITS];
  endfunction

  eepc_st_e                        state_q, state_d;
  logic [eepc_pkg::CNT_W-1:0]      cnt_q;
  logic [eepc_pkg::CNT_W-1:0]      wc_q;
  logic [2:0]                      idx_q;
  logic                            pfx_q;     // command prefix still running
  logic                            pend_q;    // accepted byte waits for a new page
  logic                            strap_done_q;
  logic                            tog_q;
  logic                            first_rd_q;
  eepc_pkg::eepc_req_s             cur_q;
  logic [eepc_pkg::ADDR_W-1:0]     last_addr_q;
  logic [eepc_pkg::DATA_W-1:0]     last_data_q;

  wire logic take    = req_valid && req_ready;
  wire logic cnt_end = cnt_q == '0;
  wire logic is_off  = cur_q.op == eepc_pkg::EEPC_OP_LOCK_OFF;
  wire logic [2:0] pfx_len = is_off ? 3'(eepc_pkg::OFF_LEN) : 3'(eepc_pkg::ON_LEN);
  // decided for the pulse being set up, so the very first pulse already carries the prefix
  wire logic need_pfx = (state_q == ST_IDLE) ? (req.op != eepc_pkg::EEPC_OP_WRITE || locked) :
                        (state_q == ST_DONE) ? locked :
                        (state_q == ST_WHIGH && pfx_q && idx_q != pfx_len - 1'b1); // [R14] [R18]
  wire logic off_nxt  = (state_q == ST_IDLE) ? req.op == eepc_pkg::EEPC_OP_LOCK_OFF : is_off;
  wire logic [2:0] idx_nxt = (state_q == ST_WHIGH) ? idx_q + 3'd1 : 3'd0;
  wire logic poll_ok  = mem_dq_i[eepc_pkg::POLL_BIT] == last_data_q[eepc_pkg::POLL_BIT];
  wire logic tog_ok   = !first_rd_q && (mem_dq_i[eepc_pkg::TOGGLE_BIT] == tog_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_INIT:  if (cnt_end) state_d = ST_IDLE; // [R11]
      ST_IDLE:  if (take) state_d = (req.op == eepc_pkg::EEPC_OP_READ) ? ST_RLOW : ST_WSET;
      ST_WSET:  state_d = ST_WLOW;
      ST_WLOW:  if (cnt_end) state_d = ST_WHIGH;
      ST_WHIGH: begin
        if (cnt_end) begin
          if (pfx_q && (idx_q != pfx_len - 1'b1 || cur_q.op == eepc_pkg::EEPC_OP_WRITE)) begin
            state_d = ST_WSET;
          end else if (cur_q.op != eepc_pkg::EEPC_OP_WRITE || cur_q.last) begin
            state_d = ST_HOLD;
          end else begin
            state_d = ST_NEXT;
          end
        end
      end
      ST_NEXT: begin
        if (take && req.op == eepc_pkg::EEPC_OP_WRITE && same_page(req.addr, cur_q.addr)) begin
          state_d = ST_WSET; // [R2] [R4] [R5]
        end else if (take || cnt_end) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD:  if (cnt_end) state_d = (cur_q.op == eepc_pkg::EEPC_OP_WRITE) ? ST_RLOW : ST_DONE;
      ST_RLOW:  begin
        if (cnt_end) begin
          if (cur_q.op == eepc_pkg::EEPC_OP_READ) state_d = ST_DONE;
          else if ((poll_ok && tog_ok) || wc_q == '0) state_d = ST_DONE; // [R8] [R9] [R10] [R22]
          else state_d = ST_RGAP;
        end
      end
      ST_RGAP:  if (cnt_end) state_d = ST_RLOW;
      ST_DONE:  state_d = pend_q ? ST_WSET : ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  // one down-counter serves every phase; loaded on entry to the next phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= INIT_N;
    end else if (state_d != state_q || (state_q == ST_WHIGH && cnt_end)) begin
      case (state_d)
        ST_WLOW:  cnt_q <= WP_N - 1'b1;   // [R13]
        ST_WHIGH: cnt_q <= GAP_N - 1'b1;
        ST_NEXT:  cnt_q <= WAIT_N;
        ST_HOLD:  cnt_q <= HOLD_N;        // [R6] [R21] [R1]
        ST_RLOW:  cnt_q <= ACC_N;
        ST_RGAP:  cnt_q <= HZ_N;
        default:  cnt_q <= '0;
      endcase
    end else if (!cnt_end) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // bound on the whole internal program cycle while polling
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wc_q <= '0;
    end else if (state_q == ST_HOLD) begin
      wc_q <= WC_N;
    end else if (wc_q != '0) begin
      wc_q <= wc_q - 1'b1;
    end
  end

  // order capture and command prefix sequencing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_q  <= '0;
      pend_q <= 1'b0;
      pfx_q  <= 1'b0;
      idx_q  <= '0;
    end else begin
      if (take) begin
        cur_q <= req;
      end
      if (state_q == ST_NEXT && state_d == ST_HOLD && take) begin
        pend_q <= 1'b1;
      end else if (state_q == ST_DONE) begin
        pend_q <= 1'b0;
      end
      if ((state_q == ST_IDLE && take) || (state_q == ST_DONE && pend_q)) begin
        pfx_q <= need_pfx; // [R18]
        idx_q <= '0;
      end else if (state_q == ST_WHIGH && cnt_end && pfx_q) begin
        idx_q <= idx_nxt;
        pfx_q <= need_pfx;
      end
    end
  end

  // controller's view of the device lock; the device keeps it across power
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      locked       <= 1'b0;  // [R15]
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      locked       <= lock_strap; // [R19]
      strap_done_q <= 1'b1;
    end else if (state_q == ST_WHIGH && cnt_end && pfx_q && idx_q == pfx_len - 1'b1) begin
      if (cur_q.op == eepc_pkg::EEPC_OP_LOCK_ON) locked <= 1'b1;  // [R16] [R17]
      if (cur_q.op == eepc_pkg::EEPC_OP_LOCK_OFF) locked <= 1'b0; // [R20]
    end
  end

  // pins: write with ce and we low, oe high; read with we high, ce and oe low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_addr    <= '0;
      mem_dq_o    <= '0;
      mem_dq_oe_n <= 1'b1;
      mem_ce_n    <= 1'b1;
      mem_oe_n    <= 1'b1;
      mem_we_n    <= 1'b1;
      last_addr_q <= '0;
      last_data_q <= '0;
    end else begin
      mem_we_n <= !(state_d == ST_WLOW);  // [R12] [R23]
      mem_ce_n <= !(state_d == ST_WLOW || state_d == ST_RLOW);
      mem_oe_n <= !(state_d == ST_RLOW);  // [R24]
      if (state_d == ST_WSET) begin
        mem_dq_oe_n <= 1'b0;
        if (need_pfx) begin
          mem_addr <= cmd_addr(off_nxt, idx_nxt); // [R16] [R25]
          mem_dq_o <= cmd_data(off_nxt, idx_nxt);
        end else begin
          mem_addr    <= take ? req.addr : cur_q.addr; // [R3] [R4]
          mem_dq_o    <= take ? req.data : cur_q.data;
          last_addr_q <= take ? req.addr : cur_q.addr;
          last_data_q <= take ? req.data : cur_q.data;
        end
      end else if (state_d == ST_RLOW) begin
        mem_dq_oe_n <= 1'b1;
        mem_addr    <= (state_q == ST_IDLE) ? req.addr :
                       (cur_q.op == eepc_pkg::EEPC_OP_READ) ? cur_q.addr : last_addr_q;
      end else if (state_d == ST_HOLD || state_d == ST_IDLE) begin
        mem_dq_oe_n <= 1'b1;
      end
    end
  end

  // status reads: toggle bit must repeat once, polled bit must be true
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tog_q      <= 1'b0;
      first_rd_q <= 1'b1;
    end else if (state_q == ST_HOLD) begin
      first_rd_q <= 1'b1;
    end else if (state_q == ST_RLOW && cnt_end) begin
      tog_q      <= mem_dq_i[eepc_pkg::TOGGLE_BIT];
      first_rd_q <= 1'b0;
    end
  end

  // user side; no order is taken while a program cycle runs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_ready  <= 1'b0;
      resp_valid <= 1'b0;
      resp       <= '0;
      busy       <= 1'b1;
    end else begin
      req_ready  <= (state_d == ST_IDLE || state_d == ST_NEXT) && !take; // [R26]
      busy       <= state_d != ST_IDLE;
      resp_valid <= state_q == ST_DONE && !pend_q;
      if (state_q == ST_RLOW && cnt_end) begin
        resp.data <= mem_dq_i;
        resp.err  <= cur_q.op != eepc_pkg::EEPC_OP_READ && !(poll_ok && tog_ok) && wc_q == '0;
      end else if (state_q == ST_HOLD && cur_q.op != eepc_pkg::EEPC_OP_WRITE) begin
        resp <= '0;
      end
    end
  end

endmodule // eepc_ctrl

/* eepc_ctrl_chk.sv */
/*
  eepc_ctrl_chk: port and pin assertions for the eeprom host controller.
  Assumes binding into eepc_ctrl; one clock domain, reset_n async low.
*/
`timescale 1ns/10ps
module eepc_ctrl_chk #(
  parameter int unsigned BLC_MAX_CYC = 200,
  parameter int unsigned INIT_CYC    = 50
) (
  // clock and reset
  input wire logic                        clk,
  input wire logic                        reset_n,
  // user side
  input wire logic                        req_valid,
  input wire logic                        req_ready,
  input wire logic                        resp_valid,
  input wire logic                        locked,
  // pins
  input wire logic [eepc_pkg::ADDR_W-1:0] mem_addr,
  input wire logic                        mem_ce_n,
  input wire logic                        mem_oe_n,
  input wire logic                        mem_we_n,
  input wire logic [eepc_pkg::DATA_W-1:0] mem_dq_o,
  input wire logic                        mem_dq_oe_n
);
  int unsigned lo_cnt, hi_cnt, oe_cnt, up_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // run counters, hi_cnt and up_cnt saturating; hi_cnt starts saturated so a first read is legal
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lo_cnt <= 0;
      hi_cnt <= BLC_MAX_CYC + 1;
      oe_cnt <= 0;
      up_cnt <= 0;
    end else begin
      lo_cnt <= mem_we_n ? 0 : lo_cnt + 1;
      hi_cnt <= !mem_we_n ? 0 : (hi_cnt > BLC_MAX_CYC ? hi_cnt : hi_cnt + 1);
      oe_cnt <= mem_oe_n ? 0 : oe_cnt + 1;
      up_cnt <= up_cnt >= INIT_CYC ? up_cnt : up_cnt + 1;
    end
  end
  AST_WRITE_GATE: assert property (
    !mem_we_n |-> !mem_ce_n && mem_oe_n && !mem_dq_oe_n) else $error("write strobe gating bad");
  AST_READ_BUS: assert property (
    !mem_oe_n |-> mem_we_n && mem_dq_oe_n && !mem_ce_n) else $error("read bus contention");
  AST_PULSE_WIDTH: assert property (
    $rose(mem_we_n) |-> lo_cnt >= eepc_pkg::WP_CYC) else $error("write pulse too short");
  AST_LATCH_STABLE: assert property (
    !mem_we_n && $past(!mem_we_n) |-> $stable(mem_addr) && $stable(mem_dq_o))
    else $error("address or data moved in pulse");
  AST_PAGE_CLOSE: assert property (
    $fell(mem_oe_n) |-> hi_cnt > BLC_MAX_CYC) else $error("read before load window closed");
  AST_LOCKOUT: assert property (
    $fell(mem_we_n) |-> up_cnt >= INIT_CYC) else $error("write inside power-on lockout");
  AST_TAKE_DROP: assert property (
    req_valid && req_ready |=> !req_ready) else $error("ready held after take");
  AST_RESP_ONE: assert property (
    resp_valid |=> !resp_valid) else $error("response longer than one cycle");
  AST_ACCESS_LEN: assert property (
    $rose(mem_oe_n) |-> oe_cnt > eepc_pkg::ACC_CYC) else $error("read access too short");
  cover property ($fell(mem_oe_n));
  cover property (resp_valid && locked);
  cover property ($rose(locked));
  cover property ($fell(locked));
endmodule // eepc_ctrl_chk
bind eepc_ctrl eepc_ctrl_chk #(.BLC_MAX_CYC(BLC_MAX_CYC), .INIT_CYC(INIT_CYC)) u_eepc_ctrl_chk (
  .clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready),
  .resp_valid(resp_valid), .locked(locked), .mem_addr(mem_addr), .mem_ce_n(mem_ce_n),
  .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .mem_dq_o(mem_dq_o), .mem_dq_oe_n(mem_dq_oe_n));

/* eepc_dev.sv */
/*
  eepc_dev: behavioural page-write eeprom with status polling and software lock.
  Assumes pins sampled on clk; lock_q is not reset, standing in for nonvolatile state.
*/
`timescale 1ns/10ps
module eepc_dev #(
  parameter int unsigned LOCKOUT = 40,
  parameter int unsigned BLC     = 200,
  parameter int unsigned WC      = 300,
  parameter logic [44:0] ON_A    = '0,
  parameter logic [23:0] ON_D    = '0,
  parameter logic [89:0] OFF_A   = '0,
  parameter logic [47:0] OFF_D   = '0
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // pins
  input  wire logic [14:0] addr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [7:0]  dq_in,
  output logic      [7:0]  dq_q
);
  logic [7:0]  mem [0:32767];
  logic [14:0] qa [$];
  logic [7:0]  qd [$];
  logic [14:0] a_lat;
  logic [7:0]  last_d;
  logic        lock_q, we_q, rd_q, tog_q, on_ok, off_ok;
  int unsigned up_q, lo_q, tmr_q, wc_q;
  wire         rd = !ce_n && !oe_n && we_n;
  initial lock_q = 1'b0;
  task automatic program_page();
    int n, st, i;
    n = qa.size();
    off_ok = n >= 6;
    on_ok = n >= 3;
    for (i = 0; i < 6; i++)
      if (off_ok && (qa[i] !== OFF_A[(5-i)*15 +: 15] || qd[i] !== OFF_D[(5-i)*8 +: 8])) off_ok = 0;
    for (i = 0; i < 3; i++)
      if (on_ok && (qa[i] !== ON_A[(2-i)*15 +: 15] || qd[i] !== ON_D[(2-i)*8 +: 8])) on_ok = 0;
    st = off_ok ? 6 : on_ok ? 3 : lock_q ? n : 0;
    if (off_ok) lock_q = 1'b0;
    else if (on_ok) lock_q = 1'b1;
    for (i = st; i < n; i++) mem[qa[i]] = qd[i];
    if (n > st) begin
      wc_q = WC;
      last_d = qd[n-1];
    end
    qa.delete();
    qd.delete();
  endtask
  // one block so status reads see the busy count of this very edge
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      up_q = 0; lo_q = 0; tmr_q = 0; wc_q = 0; we_q = 1; rd_q = 0; tog_q = 0;
      qa.delete();
      qd.delete();
      dq_q <= 8'h00;
    end else begin
      if (up_q < LOCKOUT) up_q++;
      if (wc_q != 0) wc_q--;
      if (!we_n && we_q) a_lat = addr;
      if (we_n && !we_q) begin
        if (lo_q >= 5 && up_q >= LOCKOUT && wc_q == 0) begin
          qa.push_back(a_lat);
          qd.push_back(dq_in);
          tmr_q = BLC;
        end
      end else if (!we_n) tmr_q = 0;
      else if (tmr_q != 0) begin
        tmr_q--;
        if (tmr_q == 0) program_page();
      end
      lo_q = (!we_n && !ce_n && oe_n) ? lo_q + 1 : 0;
      we_q = we_n;
      if (rd && !rd_q) tog_q = !tog_q;
      rd_q = rd;
      // released bus shows the inverse so a stale value cannot pass
      dq_q <= !rd ? ~dq_q : wc_q != 0 ? {~last_d[7], tog_q, ~addr[5:0]} : mem[addr];
    end
  end
endmodule // eepc_dev

/* tb.sv */
/*
  tb: self-checking bench for eepc_ctrl against the eepc_dev model.
  Assumes shortened load, lockout and poll counts set below.
*/
`timescale 1ns/10ps
module tb;
  localparam logic [44:0] ON_A  = {15'h0123, 15'h0456, 15'h0789};
  localparam logic [23:0] ON_D  = 24'hA1B2C3;
  localparam logic [89:0] OFF_A = {15'h0111, 15'h0222, 15'h0333, 15'h0444, 15'h0555, 15'h0666};
  localparam logic [47:0] OFF_D = 48'h0102_0304_0506;
  logic clk, reset_n, lock_strap, req_valid, req_ready, resp_valid, busy, locked;
  logic mem_ce_n, mem_oe_n, mem_we_n, mem_dq_oe_n;
  logic [14:0] mem_addr;
  logic [7:0]  mem_dq_o, mem_dq_i, dev_q, got;
  eepc_pkg::eepc_req_s  req;
  eepc_pkg::eepc_resp_s resp;
  int n_mismatch, comparisons, i;
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  assign mem_dq_i = mem_dq_oe_n ? dev_q : mem_dq_o;
  eepc_ctrl #(.BLC_MAX_CYC(200), .INIT_CYC(50), .WC_CYC(2000), .ON_ADDRS(ON_A),
    .ON_DATA(ON_D), .OFF_ADDRS(OFF_A), .OFF_DATA(OFF_D)) u_eepc_ctrl (
    .clk(clk), .reset_n(reset_n), .lock_strap(lock_strap), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .resp_valid(resp_valid), .resp(resp), .busy(busy),
    .locked(locked), .mem_addr(mem_addr), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n),
    .mem_we_n(mem_we_n), .mem_dq_o(mem_dq_o), .mem_dq_oe_n(mem_dq_oe_n), .mem_dq_i(mem_dq_i));
  // model defaults already give the short lockout, load window and program time
  eepc_dev #(.ON_A(ON_A), .ON_D(ON_D), .OFF_A(OFF_A), .OFF_D(OFF_D)) u_eepc_dev (
    .clk(clk), .reset_n(reset_n), .addr(mem_addr), .ce_n(mem_ce_n), .oe_n(mem_oe_n),
    .we_n(mem_we_n), .dq_in(mem_dq_i), .dq_q(dev_q));
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(string nm, logic e, logic g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic hang(string nm);
    n_mismatch++;
    $display("unexpected %s exp done got timeout", nm);
    wrap_up();
  endtask
  // ready is registered, so a look at the falling edge is race free
  task automatic send(eepc_pkg::eepc_op_e op, logic [14:0] a, logic [7:0] d, logic l);
    int k;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{op: op, addr: a, data: d, last: l};
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (req_ready !== 1'b1 && k < 3000);
    if (k >= 3000) hang("req_ready");
    @(posedge clk);
    req_valid <= 1'b0;
  endtask
  task automatic wait_resp();
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (resp_valid !== 1'b1 && k < 6000);
    if (k >= 6000) hang("resp_valid");
  endtask
  task automatic wr(logic [14:0] a, logic [7:0] d, logic l);
    send(eepc_pkg::EEPC_OP_WRITE, a, d, l);
    if (l) begin
      wait_resp();
      chk_bit("write err", 1'b0, resp.err);
    end
  endtask
  task automatic rd(logic [14:0] a, output logic [7:0] d);
    send(eepc_pkg::EEPC_OP_READ, a, 8'h00, 1'b1);
    wait_resp();
    d = resp.data;
  endtask
  task automatic lock_op(eepc_pkg::eepc_op_e op, logic e);
    send(op, 15'h0000, 8'h00, 1'b1);
    wait_resp();
    chk_bit("locked", e, locked);
    chk_bit("device lock", e, u_eepc_dev.lock_q);
  endtask
  initial begin
    reset_n = 0;
    lock_strap = 0;
    req_valid = 0;
    req = '0;
    repeat (8) @(posedge clk);
    chk_bit("busy in reset", 1'b1, busy);
    chk_bit("we_n in reset", 1'b1, mem_we_n);
    reset_n <= 1'b1;
    wr(15'h0040, 8'h5A, 1'b1);
    chk_bit("locked", 1'b0, locked);
    rd(15'h0040, got);
    chk_byte("byte write", 8'h5A, got);
    for (i = 0; i < 64; i++) wr({9'h002, 6'(63 - i)}, 8'h3C ^ 8'(i), i == 63);
    for (i = 0; i < 64; i++) begin
      rd({9'h002, 6'(i)}, got);
      chk_byte("page byte", 8'h3C ^ 8'(63 - i), got);
    end
    wr({9'h002, 6'd3}, 8'hE1, 1'b1);
    for (i = 2; i < 5; i++) begin
      rd({9'h002, 6'(i)}, got);
      chk_byte("partial page", i == 3 ? 8'hE1 : 8'h3C ^ 8'(63 - i), got);
    end
    // a byte for another page closes the open page and is then written on its own
    wr({9'h003, 6'd5}, 8'hA5, 1'b0);
    wr({9'h004, 6'd1}, 8'h5B, 1'b1);
    rd({9'h003, 6'd5}, got);
    chk_byte("closed page", 8'hA5, got);
    rd({9'h004, 6'd1}, got);
    chk_byte("held order", 8'h5B, got);
    lock_op(eepc_pkg::EEPC_OP_LOCK_ON, 1'b1);
    wr(15'h0200, 8'h77, 1'b1);
    rd(15'h0200, got);
    chk_byte("locked write", 8'h77, got);
    lock_op(eepc_pkg::EEPC_OP_LOCK_OFF, 1'b0);
    wr(15'h0201, 8'h12, 1'b1);
    rd(15'h0201, got);
    chk_byte("unlocked write", 8'h12, got);
    lock_op(eepc_pkg::EEPC_OP_LOCK_ON, 1'b1);
    @(posedge clk);
    reset_n <= 1'b0;
    lock_strap <= 1'b1;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    wr(15'h0300, 8'h9C, 1'b1);
    chk_bit("locked after reset", 1'b1, locked);
    rd(15'h0300, got);
    chk_byte("write after reset", 8'h9C, got);
    wrap_up();
  end
endmodule // tb
